/* design/charger_status_registers.sv */
// status register bank with ahb-lite slave, input synchronisers and flag logic
// Contract
// - battery-low flag in charge/reverse mode, zero in high-impedance
// - battery-low flag deglitched both edges
// - bit reports own interrupt driver, not pin
// - bit follows reverse-request pin level
// - charge-mode live undervoltage and overvoltage bits
// - gpio pin mirror, zero without that pin
// - mode code 00/01/10, never 11
// - charge-enable pin level in real time
// - thermal regulation bit in charge and reverse
// - charge-mode input current and voltage limiting bits
// - four-bit charge state code, invalid codes excluded
// - charge state forced to reset outside charge
// - power-good hysteresis 90/92 percent, mode-selected comparison
// - battery present from thermistor, zero when disabled
// - cold-disable bit in reverse or unzoned charge
// - hot-disable bit, limit from two-bit select
// - freezing bit stops charging in zoned charge
// - cool band bit in zoned charge
// - warm band bit in zoned charge
// - overheat bit stops charging in zoned charge
// - thermistor disable turns off zones and thermistor
//
// The implementer's own choice: the AHB-Lite register port.
`timescale 1ns/1ps
module charger_status_registers
    import charger_status_pkg::*;
#(
    parameter int unsigned DEGLITCH_CYCLES_P = DEGLITCH_CYCLES,
    parameter bit HAS_GPIO_PIN = 1'b1
) (
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic hready_in,
    input wire logic [31:0] hwdata_in,
    output logic hreadyout_out,
    output logic hresp_out,
    output logic [31:0] hrdata_out,
    input wire sense_s sense_in,
    input wire temp_config_s temp_config_in,
    input wire logic [1:0] operation_mode_in,
    input wire logic [3:0] charge_state_in,
    input wire logic irq_drive_low_in,
    output logic charge_stop_out,
    output logic cool_band_out,
    output logic warm_band_out,
    output logic temp_zones_active_out
);

    // three-stage synchroniser; a level counts once stages two and three agree
    sense_s sync1_r;
    sense_s sync2_r;
    sense_s sync3_r;
    sense_s sense_r;
    sense_s sense_nxt;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            sense_r <= '0;
        end else begin
            sync1_r <= sense_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            sense_r <= sense_nxt;
        end
    end

    // agreeing stages load the level, disagreeing stages keep the last accepted one
    assign sense_nxt = (sync2_r & sync3_r) | (sense_r & (sync2_r | sync3_r));

    // mode decode; an illegal 11 from the state machine reads as high-impedance
    wire mode_legal = operation_mode_in != 2'b11;
    wire [1:0] mode_code = mode_legal ? operation_mode_in : MODE_HIGH_IMPEDANCE;
    wire in_charge = mode_code == MODE_CHARGE;
    wire in_reverse = mode_code == MODE_REVERSE_OUTPUT;
    wire in_active = in_charge | in_reverse;

    // battery-low deglitch: in charge or reverse the flag moves only after the new level held the whole interval
    logic battery_low_r;
    logic battery_low_nxt;
    logic [DEGLITCH_CNT_W-1:0] deglitch_cnt_r;
    logic [DEGLITCH_CNT_W-1:0] deglitch_cnt_nxt;
    wire battery_low_raw = in_active & sense_r.battery_below_good;
    wire deglitch_differs = battery_low_raw != battery_low_r;
    wire [DEGLITCH_CNT_W-1:0] deglitch_last = (DEGLITCH_CYCLES_P > 1)
        ? DEGLITCH_CNT_W'(DEGLITCH_CYCLES_P - 1) : '0;
    wire deglitch_done = deglitch_cnt_r >= deglitch_last;

    // high-impedance skips the check, so the flag drops at once there
    assign battery_low_nxt = !in_active ? 1'b0 :
                             (deglitch_differs && deglitch_done) ? battery_low_raw :
                             battery_low_r;
    assign deglitch_cnt_nxt = (!in_active || !deglitch_differs || deglitch_done)
                              ? '0 : deglitch_cnt_r + 1'b1;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            battery_low_r <= 1'b0;
            deglitch_cnt_r <= '0;
        end else begin
            battery_low_r <= battery_low_nxt;
            deglitch_cnt_r <= deglitch_cnt_nxt;
        end
    end

    // power-good hysteresis; the comparison source follows the mode
    logic power_good_r;
    logic power_good_nxt;
    wire pg_above = in_reverse ? sense_r.vin_above_92 : sense_r.bats_above_92;
    wire pg_below = in_reverse ? sense_r.vin_below_90 : sense_r.bats_below_90;
    assign power_good_nxt = !in_active ? 1'b0 :
                            pg_below ? 1'b0 :
                            pg_above ? 1'b1 :
                            power_good_r;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            power_good_r <= 1'b0;
        end else begin
            power_good_r <= power_good_nxt;
        end
    end

    // temperature zones; thermistor disable also turns zone control off
    wire th_on = !temp_config_in.thermistor_disable;
    wire zones_on = th_on && !temp_config_in.temp_zone_control_disable;
    wire limit_mode = th_on && (in_reverse || (in_charge && !zones_on));
    wire zone_mode = in_charge && zones_on;
    wire cold_hit = temp_config_in.cold_limit_select ? sense_r.th_below_m10
                                                     : sense_r.th_below_0;
    wire hot_hit = (temp_config_in.hot_limit_select == HOT_LIMIT_55) ? sense_r.th_above_55 :
                   (temp_config_in.hot_limit_select == HOT_LIMIT_60) ? sense_r.th_above_60 :
                   sense_r.th_above_65;
    wire freezing = zone_mode && sense_r.th_below_0;
    wire cool = zone_mode && sense_r.th_below_10 && !sense_r.th_below_0;
    wire warm = zone_mode && sense_r.th_above_45 && !sense_r.th_above_60;
    wire overheat = zone_mode && sense_r.th_above_60;

    // charge state; only legal codes pass and only while charging
    wire charge_code_legal = charge_state_in <= CHARGE_LAST_VALID_CODE;
    wire [3:0] charge_code = (in_charge && charge_code_legal)
                             ? charge_state_in : CHARGE_RESET_CODE;

    // live register images, rebuilt every cycle so reads never return stale data
    logic [7:0] general_status_nxt;
    logic [7:0] charger_state_status_nxt;
    logic [7:0] temperature_status_nxt;
    logic [7:0] general_status_r;
    logic [7:0] charger_state_status_r;
    logic [7:0] temperature_status_r;

    always_comb begin
        general_status_nxt = STATUS_RESET;
        general_status_nxt[BATTERY_LOW_BIT] = battery_low_r;
        general_status_nxt[IRQ_DRIVER_BIT] = irq_drive_low_in;
        general_status_nxt[REVERSE_REQUEST_BIT] = sense_r.reverse_request_pin;
        general_status_nxt[UNDERVOLTAGE_BIT] = in_charge & sense_r.input_undervoltage;
        general_status_nxt[OVERVOLTAGE_BIT] = in_charge & sense_r.input_overvoltage;
        general_status_nxt[GPIO_BIT] = HAS_GPIO_PIN & sense_r.gpio_pin;
        general_status_nxt[1:0] = mode_code;
    end

    always_comb begin
        charger_state_status_nxt = STATUS_RESET;
        charger_state_status_nxt[CHARGE_ENABLE_BIT] = sense_r.charge_enable_pin;
        charger_state_status_nxt[THERMAL_ACTIVE_BIT] = in_active
                                                      & sense_r.thermal_regulation;
        charger_state_status_nxt[CURRENT_LIMIT_BIT] = in_charge
                                                     & sense_r.input_current_limit;
        charger_state_status_nxt[VOLTAGE_LIMIT_BIT] = in_charge
                                                     & sense_r.input_voltage_limit;
        charger_state_status_nxt[3:0] = charge_code;
    end

    always_comb begin
        temperature_status_nxt = STATUS_RESET;
        temperature_status_nxt[POWER_GOOD_BIT] = power_good_r;
        temperature_status_nxt[BATTERY_PRESENT_BIT] = th_on & sense_r.th_battery_seen;
        temperature_status_nxt[COLD_DISABLE_BIT] = limit_mode & cold_hit;
        temperature_status_nxt[HOT_DISABLE_BIT] = limit_mode & hot_hit;
        temperature_status_nxt[FREEZING_BIT] = freezing;
        temperature_status_nxt[COOL_BIT] = cool;
        temperature_status_nxt[WARM_BIT] = warm;
        temperature_status_nxt[OVERHEAT_BIT] = overheat;
    end

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            general_status_r <= STATUS_RESET;
            charger_state_status_r <= STATUS_RESET;
            temperature_status_r <= STATUS_RESET;
            charge_stop_out <= 1'b0;
            cool_band_out <= 1'b0;
            warm_band_out <= 1'b0;
            temp_zones_active_out <= 1'b0;
        end else begin
            general_status_r <= general_status_nxt;
            charger_state_status_r <= charger_state_status_nxt;
            temperature_status_r <= temperature_status_nxt;
            charge_stop_out <= freezing | overheat;
            cool_band_out <= cool;
            warm_band_out <= warm;
            temp_zones_active_out <= zones_on;
        end
    end

    // ahb-lite slave: zero wait states, always okay; data is never stored
    wire ahb_take = hsel_in && htrans_in[HTRANS_ACTIVE_BIT] && hready_in;
    wire ahb_read = ahb_take && !hwrite_in;
    wire [9:0] word_addr = {haddr_in[9:2], 2'b00};
    wire addr_in_window = haddr_in[31:10] == '0;
    wire [7:0] read_sel = !addr_in_window ? 8'h00 :
                          (word_addr == GENERAL_STATUS_ADDR) ? general_status_r :
                          (word_addr == CHARGER_STATE_STATUS_ADDR) ? charger_state_status_r :
                          (word_addr == TEMPERATURE_STATUS_ADDR) ? temperature_status_r :
                          8'h00;
    logic [31:0] hrdata_nxt;
    assign hrdata_nxt = ahb_read ? {24'h000000, read_sel} : 32'h00000000;

    always_ff @(posedge clk_sys_in) begin
        if (reset_in) begin
            hrdata_out <= 32'h00000000;
        end else begin
            hrdata_out <= hrdata_nxt;
        end
    end

    assign hreadyout_out = 1'b1;
    assign hresp_out = 1'b0;

endmodule : charger_status_registers

/* design/charger_status_pkg.sv */
// package: register map, field positions, timing and carrier types for the status bank
package charger_status_pkg;

    // register indices; the byte address is four times the index
    localparam logic [7:0] GENERAL_STATUS_IDX = 8'h02;
    localparam logic [7:0] CHARGER_STATE_STATUS_IDX = 8'h03;
    localparam logic [7:0] TEMPERATURE_STATUS_IDX = 8'h04;
    localparam logic [9:0] GENERAL_STATUS_ADDR = {GENERAL_STATUS_IDX, 2'b00};
    localparam logic [9:0] CHARGER_STATE_STATUS_ADDR = {CHARGER_STATE_STATUS_IDX, 2'b00};
    localparam logic [9:0] TEMPERATURE_STATUS_ADDR = {TEMPERATURE_STATUS_IDX, 2'b00};
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // general_status fields
    localparam int BATTERY_LOW_BIT = 7;
    localparam int IRQ_DRIVER_BIT = 6;
    localparam int REVERSE_REQUEST_BIT = 5;
    localparam int UNDERVOLTAGE_BIT = 4;
    localparam int OVERVOLTAGE_BIT = 3;
    localparam int GPIO_BIT = 2;

    // charger_state_status fields
    localparam int CHARGE_ENABLE_BIT = 7;
    localparam int THERMAL_ACTIVE_BIT = 6;
    localparam int CURRENT_LIMIT_BIT = 5;
    localparam int VOLTAGE_LIMIT_BIT = 4;

    // temperature_status fields
    localparam int POWER_GOOD_BIT = 7;
    localparam int BATTERY_PRESENT_BIT = 6;
    localparam int COLD_DISABLE_BIT = 5;
    localparam int HOT_DISABLE_BIT = 4;
    localparam int FREEZING_BIT = 3;
    localparam int COOL_BIT = 2;
    localparam int WARM_BIT = 1;
    localparam int OVERHEAT_BIT = 0;

    // operating mode codes
    localparam logic [1:0] MODE_HIGH_IMPEDANCE = 2'b00;
    localparam logic [1:0] MODE_CHARGE = 2'b01;
    localparam logic [1:0] MODE_REVERSE_OUTPUT = 2'b10;

    // charge state codes
    localparam logic [3:0] CHARGE_RESET_CODE = 4'h0;
    localparam logic [3:0] CHARGE_LAST_VALID_CODE = 4'ha;

    // hot limit select codes
    localparam logic [1:0] HOT_LIMIT_55 = 2'b00;
    localparam logic [1:0] HOT_LIMIT_60 = 2'b01;

    // battery-low deglitch
    localparam int CLK_HZ = 40_000_000;
    localparam int DEGLITCH_MS = 16;
    localparam int DEGLITCH_CYCLES = (CLK_HZ / 1000) * DEGLITCH_MS;
    localparam int DEGLITCH_CNT_W = 20;

    // ahb transfer type bit that marks an active transfer
    localparam int HTRANS_ACTIVE_BIT = 1;

    // levels arriving from pins and analogue comparators, all asynchronous
    typedef struct packed {
        logic reverse_request_pin;
        logic charge_enable_pin;
        logic gpio_pin;
        logic input_undervoltage;
        logic input_overvoltage;
        logic battery_below_good;
        logic thermal_regulation;
        logic input_current_limit;
        logic input_voltage_limit;
        logic vin_above_92;
        logic vin_below_90;
        logic bats_above_92;
        logic bats_below_90;
        logic th_battery_seen;
        logic th_below_0;
        logic th_below_m10;
        logic th_below_10;
        logic th_above_45;
        logic th_above_55;
        logic th_above_60;
        logic th_above_65;
    } sense_s;

    // control bits held by the control registers elsewhere, same clock
    typedef struct packed {
        logic thermistor_disable;
        logic temp_zone_control_disable;
        logic cold_limit_select;
        logic [1:0] hot_limit_select;
    } temp_config_s;

endpackage : charger_status_pkg

/* verif/status_props.sv */
// checker: read-path and status-image properties of the status bank
`timescale 1ns/1ps
module status_props
    import charger_status_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic reset_in,
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_out,
    input wire temp_config_s temp_config_in,
    input wire logic [1:0] operation_mode_in,
    input wire logic irq_drive_low_in,
    input wire logic temp_zones_active_out
);
    logic rd_r, zon1_r, zon2_r, i1_r, i2_r, i3_r;
    logic [1:0] m1_r, m2_r, m3_r;
    logic [2:0] hiz_cnt_r;
    logic [31:0] addr_r;
    wire logic take = hsel_in && htrans_in[HTRANS_ACTIVE_BIT] && hready_in && !hwrite_in;
    wire logic rd_gen = rd_r && addr_r == 32'(GENERAL_STATUS_ADDR);
    wire logic rd_chg = rd_r && addr_r == 32'(CHARGER_STATE_STATUS_ADDR);
    wire logic hit = rd_gen || rd_chg || addr_r == 32'(TEMPERATURE_STATUS_ADDR);
    wire logic mstab = m1_r == m2_r && m2_r == m3_r;
    wire logic istab = i1_r == i2_r && i2_r == i3_r;
    wire logic zon = !(temp_config_in.thermistor_disable
                       || temp_config_in.temp_zone_control_disable);
    // history is left unreset so it always holds the true past inputs
    always_ff @(posedge clk_sys_in) begin
        rd_r <= take && !reset_in;
        addr_r <= haddr_in;
        {m3_r, m2_r, m1_r} <= {m2_r, m1_r, operation_mode_in};
        {i3_r, i2_r, i1_r} <= {i2_r, i1_r, irq_drive_low_in};
        {zon2_r, zon1_r} <= {zon1_r, zon};
        hiz_cnt_r <= (reset_in || ^operation_mode_in) ? 3'h0 : hiz_cnt_r + 3'(hiz_cnt_r != 3'h7);
    end
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    a_upper_zero: assert property (hrdata_out[31:8] == 24'h0)
        else $error("read data upper bits set");
    a_idle_zero: assert property (!rd_r |-> hrdata_out == 32'h0)
        else $error("read data outside data phase");
    a_unmapped_zero: assert property (rd_r && !hit |-> hrdata_out == 32'h0)
        else $error("unmapped read not zero");
    a_mode_echo: assert property (rd_gen && mstab |->
        hrdata_out[1:0] == (m1_r == 2'b11 ? MODE_HIGH_IMPEDANCE : m1_r)) else $error("mode wrong");
    a_charge_gate: assert property (rd_chg && mstab && m1_r != MODE_CHARGE |->
        hrdata_out[3:0] == CHARGE_RESET_CODE) else $error("charge state outside charge");
    a_lowbat_hiz: assert property (rd_gen && hiz_cnt_r >= 3'h6 |->
        !hrdata_out[BATTERY_LOW_BIT]) else $error("battery low in high impedance");
    a_irq_echo: assert property (rd_gen && istab |-> hrdata_out[IRQ_DRIVER_BIT] == i2_r)
        else $error("irq driver bit wrong");
    a_zones_on: assert property (!$past(reset_in) && zon1_r == zon2_r |->
        temp_zones_active_out == zon1_r) else $error("zone control state wrong");
    c_read_charge: cover property (rd_gen && mstab && m1_r == MODE_CHARGE);
    c_unmapped: cover property (rd_r && !hit);
    c_zoned: cover property (temp_zones_active_out && m1_r == MODE_CHARGE);
endmodule : status_props

/* verif/ahb_host.sv */
// partner: ahb-lite host issuing single word transfers to the status bank
`timescale 1ns/1ps
module ahb_host (
    input wire logic clk_in,
    input wire logic hready_in,
    input wire logic [31:0] hrdata_in,
    output logic hsel_out,
    output logic [31:0] haddr_out,
    output logic [1:0] htrans_out,
    output logic hwrite_out,
    output logic [2:0] hsize_out,
    output logic [31:0] hwdata_out
);
    initial begin
        {hsel_out, haddr_out, htrans_out, hwrite_out, hwdata_out} = 68'h0;
        hsize_out = 3'h2;
    end
    // no wait count is assumed: each phase lasts until hready is seen high
    task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wdata,
            output logic [31:0] rdata);
        @(posedge clk_in);
        {hsel_out, haddr_out, htrans_out, hwrite_out} <= {1'b1, addr, 2'b10, wr};
        hwdata_out <= ~hwdata_out;
        do @(posedge clk_in); while (hready_in !== 1'b1);
        {hsel_out, htrans_out, hwdata_out} <= {1'b0, 2'b00, wdata};
        do @(posedge clk_in); while (hready_in !== 1'b1);
        rdata = hrdata_in;
    endtask : xfer
endmodule : ahb_host

/* verif/tb.sv */
// testbench: status bank against a behavioural model, driven through the host model
`timescale 1ns/1ps
module tb;
    import charger_status_pkg::*;
    logic clk, rst, irq, pg_m;
    logic [1:0] mode;
    logic [3:0] cs, e_pin;
    logic [7:0] e_gen, e_chg, e_tmp;
    logic [31:0] seed = 32'd54111;
    sense_s sense;
    temp_config_s cfg;
    wire logic hsel, hwrite, hready, hresp, c_stop, c_cool, c_warm, c_zone;
    wire logic [1:0] htrans;
    wire logic [2:0] hsize;
    wire logic [31:0] haddr, hwdata, hrdata;
    int n_errors = 0;
    int num_checks = 0;
    localparam logic [31:0] GEN = 32'(GENERAL_STATUS_ADDR);
    localparam logic [31:0] UNM [4] = '{32'h0, 32'h14, 32'h408, 32'hfffffff0};
    charger_status_registers #(.DEGLITCH_CYCLES_P(8), .HAS_GPIO_PIN(1'b1)) u_dut (
        .clk_sys_in(clk), .reset_in(rst), .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
        .hwrite_in(hwrite), .hsize_in(hsize), .hready_in(hready), .hwdata_in(hwdata),
        .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata), .sense_in(sense),
        .temp_config_in(cfg), .operation_mode_in(mode), .charge_state_in(cs),
        .irq_drive_low_in(irq), .charge_stop_out(c_stop), .cool_band_out(c_cool),
        .warm_band_out(c_warm), .temp_zones_active_out(c_zone));
    ahb_host u_host (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
        .hwdata_out(hwdata));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic chk_reg(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_reg
    task automatic chk_pin(input logic [3:0] exp);
        chk_reg("zone_outputs", {28'h0, exp}, {28'h0, c_stop, c_cool, c_warm, c_zone});
    endtask : chk_pin
    task automatic rd_chk(input string name, input logic [31:0] addr, input logic [31:0] mask,
            input logic [31:0] exp);
        logic [31:0] got;
        u_host.xfer(1'b0, addr, 32'h0, got);
        chk_reg(name, exp, got & mask);
        chk_reg("hresp", 32'h0, {31'h0, hresp});
    endtask : rd_chk
    task automatic model();
        logic chg, rev, act, zact, zc, gate, cold, hot;
        chg = mode == MODE_CHARGE;
        rev = mode == MODE_REVERSE_OUTPUT;
        act = chg || rev;
        zact = !cfg.thermistor_disable && !cfg.temp_zone_control_disable;
        zc = chg && zact;
        gate = (rev || (chg && cfg.temp_zone_control_disable)) && !cfg.thermistor_disable;
        if (!act) pg_m = 1'b0;
        else if (rev ? sense.vin_below_90 : sense.bats_below_90) pg_m = 1'b0;
        else if (rev ? sense.vin_above_92 : sense.bats_above_92) pg_m = 1'b1;
        cold = cfg.cold_limit_select ? sense.th_below_m10 : sense.th_below_0;
        hot = cfg.hot_limit_select == HOT_LIMIT_55 ? sense.th_above_55 :
            cfg.hot_limit_select == HOT_LIMIT_60 ? sense.th_above_60 : sense.th_above_65;
        e_gen = {act && sense.battery_below_good, irq, sense.reverse_request_pin,
            chg && sense.input_undervoltage, chg && sense.input_overvoltage, sense.gpio_pin,
            mode == 2'b11 ? MODE_HIGH_IMPEDANCE : mode};
        e_chg = {sense.charge_enable_pin, act && sense.thermal_regulation,
            chg && sense.input_current_limit, chg && sense.input_voltage_limit,
            chg && cs <= CHARGE_LAST_VALID_CODE ? cs : CHARGE_RESET_CODE};
        e_tmp = {pg_m, !cfg.thermistor_disable && sense.th_battery_seen, gate && cold,
            gate && hot, zc && sense.th_below_0, zc && sense.th_below_10 && !sense.th_below_0,
            zc && sense.th_above_45 && !sense.th_above_60, zc && sense.th_above_60};
        e_pin = {e_tmp[3] || e_tmp[0], e_tmp[2], e_tmp[1], zact};
    endtask : model
    // inputs held 20 cycles so synchronisers, deglitch and hysteresis all settle
    task automatic step(input int i);
        logic [31:0] r;
        r = rnd();
        @(posedge clk);
        sense <= r[20:0];
        cfg <= {r[25] & r[31], r[24] & r[31], r[23:21]};
        cs <= r[29:26];
        irq <= r[30];
        // high-impedance while new levels cross the synchronisers, so power-good
        // history never sees the new mode against stale comparator levels
        mode <= MODE_HIGH_IMPEDANCE;
        repeat (6) @(posedge clk);
        mode <= 2'(i);
        repeat (20) @(posedge clk);
        pg_m = 1'b0;
        model();
        u_host.xfer(1'b1, GEN + 32'(4 * (i % 3)), rnd(), r);
        rd_chk("general_status", GEN, '1, {24'h0, e_gen});
        rd_chk("charger_state_status", GEN + 32'h4, '1, {24'h0, e_chg});
        rd_chk("temperature_status", GEN + 32'h8, '1, {24'h0, e_tmp});
        rd_chk("temperature_zones", GEN + 32'h8, '1, {24'h0, e_tmp});
        chk_pin(e_pin);
        // with neither threshold crossed, power-good must keep its set state
        if (pg_m) begin
            @(posedge clk);
            {sense.vin_above_92, sense.bats_above_92} <= 2'b00;
            repeat (8) @(posedge clk);
            rd_chk("power_good_hold", GEN + 32'h8, 32'h80, 32'h80);
        end
    endtask : step
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : wrap_up
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        n_errors++;
        $display("ERROR watchdog expected done seen timeout");
        wrap_up();
    end
    initial begin
        rst = 1'b1;
        {sense, cfg, mode, cs, irq, pg_m} = 34'h0;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 3; a++) rd_chk("reset_value", GEN + 32'(4 * a), '1, 32'h0);
        $display("test reset done");
        // short pulses of either polarity must not reach the flag
        for (int k = 0; k < 7; k++) begin
            @(posedge clk);
            sense.battery_below_good <= 1'(7'b1101010 >> k);
            mode <= (k == 6) ? MODE_HIGH_IMPEDANCE : MODE_CHARGE;
            repeat ((k == 1 || k == 4) ? 0 : 25) @(posedge clk);
            rd_chk("battery_low", GEN, 32'h80, 32'((7'b0111000 >> k) & 1) << 7);
        end
        $display("test battery_low done");
        for (int i = 0; i < 48; i++) step(i);
        $display("test random done");
        for (int a = 0; a < 4; a++) rd_chk("unmapped", UNM[a], '1, 32'h0);
        $display("test unmapped done");
        wrap_up();
    end
endmodule : tb
bind charger_status_registers status_props u_props (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in),
    .hwrite_in(hwrite_in), .hready_in(hready_in), .hrdata_out(hrdata_out),
    .temp_config_in(temp_config_in), .operation_mode_in(operation_mode_in),
    .irq_drive_low_in(irq_drive_low_in), .temp_zones_active_out(temp_zones_active_out));
